// ### common/vlan_tag_priority_queue_consts.svh
// constants for the vlan tag and priority queue block
`ifndef VLAN_TAG_PRIORITY_QUEUE_CONSTS_SVH
`define VLAN_TAG_PRIORITY_QUEUE_CONSTS_SVH

`define ADDR_W 8
`define ADDR_CTRL 8'h00
`define ADDR_THRESH 8'h04
`define ADDR_DROPS 8'h08
`define ADDR_VID_SEL 8'h0C
`define ADDR_MEMBER 8'h10
`define ADDR_PORT_CFG_PAGE 2'h1
`define ADDR_PORT_STAT_PAGE 2'h2

`define CTRL_VLAN_EN_BIT 0
`define THRESH_RESET 3'h4
`define PVID_RESET 12'h001
`define PRIO_RESET 3'h0

`define CFG_STATE_LSB 0
`define CFG_HYBRID_BIT 3
`define CFG_PRIO_LSB 4
`define CFG_NONDESIG_BIT 7
`define CFG_PVID_LSB 16

`define STAT_NORM_LSB 8
`define STAT_HIGH_LSB 16

`define TCI_PCP_LSB 13
`define TCI_VID_W 12
`define TAG_OFFSET_BYTES 12
`define VID_COUNT 4096

`endif

// ### common/vlan_tag_priority_queue_pkg.sv
// types for the vlan tag and priority queue block
package vlan_tag_priority_queue_pkg;

  typedef enum logic [2:0] {
    STP_DISABLED = 3'b000,
    STP_BLOCKING = 3'b001,
    STP_LISTENING = 3'b010,
    STP_LEARNING = 3'b011,
    STP_FORWARDING = 3'b100
  } stp_state_e;

  typedef logic [11:0] vid_t;

endpackage

// ### design/vlan_tag_priority_queue.sv
// per-port stp gating, vlan tagging and two-class egress queues of a switch
`include "vlan_tag_priority_queue_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module vlan_tag_priority_queue
  import vlan_tag_priority_queue_pkg::*;
#(
  parameter int NPORT = 4,
  parameter int PW = 2,
  parameter int DEPTH = 8,
  parameter int HW = 16
)
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [`ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic in_valid_i,
  input wire logic [PW-1:0] in_port_i,
  input wire logic [PW-1:0] out_port_i,
  input wire logic in_tagged_i,
  input wire logic [15:0] in_tci_i,
  input wire logic in_bpdu_i,
  input wire logic [HW-1:0] in_handle_i,
  input wire logic [NPORT-1:0] tx_ready_i,
  output logic [NPORT-1:0] tx_valid_o,
  output logic [NPORT-1:0] tx_tagged_o,
  output logic [NPORT*16-1:0] tx_tci_o,
  output logic [NPORT*HW-1:0] tx_handle_o,
  output logic bpdu_valid_o,
  output logic [PW-1:0] bpdu_port_o,
  output logic [HW-1:0] bpdu_handle_o
);
  import vlan_tag_priority_queue_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam int NQ = 2 * NPORT;
  localparam int EW = 17 + HW;

  // configuration and status registers
  logic vlan_en;
  logic [2:0] threshold;
  logic [15:0] drops;
  vid_t vid_sel;
  stp_state_e port_state [NPORT];
  logic [NPORT-1:0] port_hybrid;
  logic [NPORT-1:0] port_nondesig;
  logic [2:0] port_prio [NPORT];
  vid_t port_pvid [NPORT];
  logic [NPORT-1:0] member [`VID_COUNT];
  logic next_vlan_en;
  logic [2:0] next_threshold;
  logic [15:0] next_drops;
  vid_t next_vid_sel;
  stp_state_e next_port_state [NPORT];
  logic [NPORT-1:0] next_port_hybrid;
  logic [NPORT-1:0] next_port_nondesig;
  logic [2:0] next_port_prio [NPORT];
  vid_t next_port_pvid [NPORT];
  logic [31:0] next_rdata;

  // queue storage, entry is {orig tagged, tci, handle}
  logic [EW-1:0] qmem [NQ][DEPTH];
  logic [AW-1:0] qwr [NQ];
  logic [AW-1:0] qrd [NQ];
  logic [CW-1:0] qcnt [NQ];
  logic [AW-1:0] next_qwr [NQ];
  logic [AW-1:0] next_qrd [NQ];
  logic [CW-1:0] next_qcnt [NQ];

  // egress and bpdu output registers
  logic [NPORT-1:0] next_tx_valid;
  logic [NPORT-1:0] next_tx_tagged;
  logic [NPORT*16-1:0] next_tx_tci;
  logic [NPORT*HW-1:0] next_tx_handle;
  logic next_bpdu_valid;

  // ingress decisions
  stp_state_e eff_state [NPORT];
  logic [NPORT-1:0] fwd;
  logic in_range;
  logic drop_tag;
  vid_t in_vid;
  logic [2:0] in_prio;
  logic in_hi;
  logic [PW:0] enq_q;
  logic enq;
  logic [EW-1:0] enq_entry;
  logic [NPORT-1:0] pop_hi;
  logic [NPORT-1:0] pop_no;
  logic [NPORT-1:0] hi_busy;

  // effective stp state, non-designated port forced to blocking
  always_comb
  begin
    for (int p = 0; p < NPORT; p++)
    begin
      eff_state[p] = port_nondesig[p] ? STP_BLOCKING : port_state[p];
      fwd[p] = (eff_state[p] == STP_FORWARDING);
    end
  end

  // ingress classification and tagging
  always_comb
  begin
    in_range = ({1'b0, out_port_i} < (PW+1)'(NPORT));
    drop_tag = vlan_en & ~port_hybrid[in_port_i] & in_tagged_i;
    // with vlan on untagged gets port vid; otherwise the vid comes from the tci
    in_vid = (vlan_en & ~in_tagged_i) ? port_pvid[in_port_i] : in_tci_i[`TCI_VID_W-1:0];
    in_prio = in_tagged_i ? in_tci_i[15:`TCI_PCP_LSB] : port_prio[in_port_i];
    in_hi = vlan_en & (in_prio >= threshold);
    enq_q = {out_port_i, in_hi};
    enq = in_valid_i & ~in_bpdu_i & in_range & fwd[in_port_i] & fwd[out_port_i] & ~drop_tag
      & (qcnt[enq_q] != CW'(DEPTH));
    // tag laid out as pcp, dei, vid
    enq_entry = {in_tagged_i, in_prio, in_tci_i[12] & in_tagged_i, in_vid, in_handle_i};
  end

  // strict priority dequeue per egress port
  always_comb
  begin
    for (int p = 0; p < NPORT; p++)
    begin
      hi_busy[p] = (qcnt[2*p+1] != '0);
      pop_hi[p] = (~tx_valid_o[p] | tx_ready_i[p]) & fwd[p] & (qcnt[2*p+1] != '0);
      pop_no[p] = (~tx_valid_o[p] | tx_ready_i[p]) & fwd[p] & (qcnt[2*p+1] == '0) & (qcnt[2*p] != '0);
    end
  end

  // queue pointers, counts and egress registers next values
  always_comb
  begin
    logic [EW-1:0] e;
    logic pop;
    e = '0;
    pop = 1'b0;
    next_tx_valid = tx_valid_o;
    next_tx_tagged = tx_tagged_o;
    next_tx_tci = tx_tci_o;
    next_tx_handle = tx_handle_o;
    for (int q = 0; q < NQ; q++)
    begin
      pop = (q % 2 == 1) ? pop_hi[q/2] : pop_no[q/2];
      next_qwr[q] = qwr[q] + AW'(enq && (enq_q == (PW+1)'(q)));
      next_qrd[q] = qrd[q] + AW'(pop);
      next_qcnt[q] = qcnt[q] + CW'(enq && (enq_q == (PW+1)'(q))) - CW'(pop);
    end
    for (int p = 0; p < NPORT; p++)
    begin
      if (tx_ready_i[p])
        next_tx_valid[p] = 1'b0;
      if (pop_hi[p] | pop_no[p])
      begin
        e = pop_hi[p] ? qmem[2*p+1][qrd[2*p+1]] : qmem[2*p][qrd[2*p]];
        next_tx_valid[p] = 1'b1;
        // access strips, hybrid keeps only for foreign vlans
        if (vlan_en)
          next_tx_tagged[p] = port_hybrid[p] & ~member[e[HW +: 12]][p];
        else
          next_tx_tagged[p] = e[EW-1];
        next_tx_tci[p*16 +: 16] = e[HW +: 16];
        next_tx_handle[p*HW +: HW] = e[HW-1:0];
      end
    end
  end

  // bpdus go to the stp engine unless the port is disabled
  always_comb
  begin
    next_bpdu_valid = in_valid_i & in_bpdu_i & (port_state[in_port_i] != STP_DISABLED);
  end

  // register writes and read data
  always_comb
  begin
    int idx;
    idx = int'(reg_addr_i[5:2]);
    next_vlan_en = vlan_en;
    next_threshold = threshold;
    next_vid_sel = vid_sel;
    next_drops = drops + 16'(in_valid_i & ~in_bpdu_i & ~enq);
    next_port_hybrid = port_hybrid;
    next_port_nondesig = port_nondesig;
    for (int p = 0; p < NPORT; p++)
    begin
      next_port_state[p] = port_state[p];
      next_port_prio[p] = port_prio[p];
      next_port_pvid[p] = port_pvid[p];
    end
    next_rdata = '0;
    if (reg_wr_i)
    begin
      if (reg_addr_i == `ADDR_CTRL)
        next_vlan_en = reg_wdata_i[`CTRL_VLAN_EN_BIT];
      if (reg_addr_i == `ADDR_THRESH)
        next_threshold = reg_wdata_i[2:0];
      if (reg_addr_i == `ADDR_DROPS)
        next_drops = '0;
      if (reg_addr_i == `ADDR_VID_SEL)
        next_vid_sel = reg_wdata_i[11:0];
      if (reg_addr_i[7:6] == `ADDR_PORT_CFG_PAGE && idx < NPORT)
      begin
        // illegal state codes leave the state unchanged
        if (reg_wdata_i[`CFG_STATE_LSB +: 3] <= 3'(STP_FORWARDING))
          next_port_state[idx] = stp_state_e'(reg_wdata_i[`CFG_STATE_LSB +: 3]);
        next_port_hybrid[idx] = reg_wdata_i[`CFG_HYBRID_BIT];
        next_port_prio[idx] = reg_wdata_i[`CFG_PRIO_LSB +: 3];
        next_port_nondesig[idx] = reg_wdata_i[`CFG_NONDESIG_BIT];
        next_port_pvid[idx] = reg_wdata_i[`CFG_PVID_LSB +: 12];
      end
    end
    if (reg_rd_i)
    begin
      if (reg_addr_i == `ADDR_CTRL)
        next_rdata[`CTRL_VLAN_EN_BIT] = vlan_en;
      if (reg_addr_i == `ADDR_THRESH)
        next_rdata[2:0] = threshold;
      if (reg_addr_i == `ADDR_DROPS)
        next_rdata[15:0] = drops;
      if (reg_addr_i == `ADDR_VID_SEL)
        next_rdata[11:0] = vid_sel;
      if (reg_addr_i == `ADDR_MEMBER)
        next_rdata[NPORT-1:0] = member[vid_sel];
      if (reg_addr_i[7:6] == `ADDR_PORT_CFG_PAGE && idx < NPORT)
      begin
        next_rdata[`CFG_STATE_LSB +: 3] = port_state[idx];
        next_rdata[`CFG_HYBRID_BIT] = port_hybrid[idx];
        next_rdata[`CFG_PRIO_LSB +: 3] = port_prio[idx];
        next_rdata[`CFG_NONDESIG_BIT] = port_nondesig[idx];
        next_rdata[`CFG_PVID_LSB +: 12] = port_pvid[idx];
      end
      if (reg_addr_i[7:6] == `ADDR_PORT_STAT_PAGE && idx < NPORT)
      begin
        next_rdata[2:0] = eff_state[idx];
        next_rdata[`STAT_NORM_LSB +: CW] = qcnt[2*idx];
        next_rdata[`STAT_HIGH_LSB +: CW] = qcnt[2*idx+1];
      end
    end
  end

  // register all state except queue and membership storage
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      vlan_en <= 1'b0;
      threshold <= `THRESH_RESET;
      drops <= '0;
      vid_sel <= '0;
      port_hybrid <= '0;
      port_nondesig <= '0;
      for (int p = 0; p < NPORT; p++)
      begin
        port_state[p] <= STP_DISABLED;
        port_prio[p] <= `PRIO_RESET;
        port_pvid[p] <= `PVID_RESET;
      end
      for (int q = 0; q < NQ; q++)
      begin
        qwr[q] <= '0;
        qrd[q] <= '0;
        qcnt[q] <= '0;
      end
      reg_rdata_o <= '0;
      tx_valid_o <= '0;
      tx_tagged_o <= '0;
      tx_tci_o <= '0;
      tx_handle_o <= '0;
      bpdu_valid_o <= 1'b0;
      bpdu_port_o <= '0;
      bpdu_handle_o <= '0;
    end
    else
    begin
      vlan_en <= next_vlan_en;
      threshold <= next_threshold;
      drops <= next_drops;
      vid_sel <= next_vid_sel;
      port_hybrid <= next_port_hybrid;
      port_nondesig <= next_port_nondesig;
      port_state <= next_port_state;
      port_prio <= next_port_prio;
      port_pvid <= next_port_pvid;
      qwr <= next_qwr;
      qrd <= next_qrd;
      qcnt <= next_qcnt;
      reg_rdata_o <= next_rdata;
      tx_valid_o <= next_tx_valid;
      tx_tagged_o <= next_tx_tagged;
      tx_tci_o <= next_tx_tci;
      tx_handle_o <= next_tx_handle;
      bpdu_valid_o <= next_bpdu_valid;
      bpdu_port_o <= in_port_i;
      bpdu_handle_o <= in_handle_i;
    end
  end

  // queue and membership storage, no reset
  always_ff @(posedge clock_i)
  begin
    if (rst_n_i && enq)
      qmem[enq_q][qwr[enq_q]] <= enq_entry;
    if (rst_n_i && reg_wr_i && reg_addr_i == `ADDR_MEMBER)
      member[vid_sel] <= reg_wdata_i[NPORT-1:0];
  end

  // checks on the outputs and the queue handling
  property p_tx_only_forwarding;
    @(posedge clock_i) disable iff (!rst_n_i)
    ~|(tx_valid_o & ~$past(tx_valid_o) & ~$past(fwd));
  endproperty
  a_tx_only_forwarding: assert property (p_tx_only_forwarding) else $error("pop from non-forwarding port");

  property p_no_pop_blocked;
    @(posedge clock_i) disable iff (!rst_n_i)
    ~|((pop_hi | pop_no) & ~fwd);
  endproperty
  a_no_pop_blocked: assert property (p_no_pop_blocked) else $error("blocked port dequeued a frame");

  property p_access_drops_tagged;
    @(posedge clock_i) disable iff (!rst_n_i)
    (in_valid_i && !in_bpdu_i && vlan_en && !port_hybrid[in_port_i] && in_tagged_i && drops != 16'hFFFF
      && !(reg_wr_i && reg_addr_i == `ADDR_DROPS)) |=> (drops == $past(drops) + 16'h1);
  endproperty
  a_access_drops_tagged: assert property (p_access_drops_tagged) else $error("tagged frame on access port kept");

  property p_high_first;
    @(posedge clock_i) disable iff (!rst_n_i)
    ~|(pop_no & hi_busy);
  endproperty
  a_high_first: assert property (p_high_first) else $error("normal queue served beside high");

  property p_thresh_reset;
    @(posedge clock_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> (threshold == `THRESH_RESET) && (qcnt[1] == '0);
  endproperty
  a_thresh_reset: assert property (p_thresh_reset) else $error("threshold not 4 after reset");

  property p_access_untagged_out;
    @(posedge clock_i) disable iff (!rst_n_i)
    (vlan_en && |((pop_hi | pop_no) & ~port_hybrid)) |=> ~|(tx_tagged_o & $past((pop_hi | pop_no) & ~port_hybrid));
  endproperty
  a_access_untagged_out: assert property (p_access_untagged_out) else $error("access port sent a tag");

  property p_no_prio_when_off;
    @(posedge clock_i) disable iff (!rst_n_i)
    (!vlan_en && enq) |=> (qcnt[{$past(out_port_i), 1'b1}] == $past(qcnt[{out_port_i, 1'b1}]) - CW'($past(pop_hi[out_port_i])));
  endproperty
  a_no_prio_when_off: assert property (p_no_prio_when_off) else $error("high queue filled with vlan off");

  property p_untagged_gets_pvid;
    @(posedge clock_i) disable iff (!rst_n_i)
    (enq && vlan_en && !in_tagged_i) |-> (enq_entry[HW +: 12] == port_pvid[in_port_i])
      && (enq_entry[HW+13 +: 3] == port_prio[in_port_i]);
  endproperty
  a_untagged_gets_pvid: assert property (p_untagged_gets_pvid) else $error("untagged frame lacks port vid");

endmodule

`default_nettype wire

// ### verif/egress_sink.sv
// egress station model: takes descriptors promptly or slowly, can stall
`timescale 1ns/1ps
`default_nettype none

module egress_sink
#(
  parameter int NPORT = 4
)
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [NPORT-1:0] stall_i,
  input wire logic slow_i,
  output logic [NPORT-1:0] tx_ready_o
);
  logic phase;

  // accept only every other cycle in slow mode
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      phase <= 1'b0;
    else
      phase <= ~phase;
  end

  // ready per station, held low while a station stalls
  assign tx_ready_o = ~stall_i & {NPORT{~slow_i | phase}};
endmodule

`default_nettype wire

// ### verif/vlan_tag_priority_queue_tb_top.sv
// self-checking bench for the vlan tag and priority queue block
`include "vlan_tag_priority_queue_consts.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED at %0t: got %h exp %h", $time, (g), (e)); end end

module vlan_tag_priority_queue_tb_top;
  import vlan_tag_priority_queue_pkg::*;
  typedef struct packed {
    logic [1:0] inp;
    logic [1:0] outp;
    logic tg;
    logic [15:0] tci;
    logic etg;
    logic [15:0] etci;
  } row_s;
  logic clock_i, rst_n_i, reg_wr, reg_rd, in_valid, in_tagged, in_bpdu, slow, bpdu_valid;
  logic [`ADDR_W-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [1:0] in_port, out_port, bpdu_port;
  logic [15:0] in_tci, in_handle, bpdu_handle, h;
  logic [3:0] tx_ready, tx_valid, tx_tagged, stall;
  logic [63:0] tx_tci, tx_handle;
  logic [32:0] got_q [4][$];
  logic [32:0] got;
  logic [7:0] ca [13];
  logic [31:0] cd [13];
  row_s rows [5];
  int mismatches, tests_run, cycles;

  vlan_tag_priority_queue vlan_tag_priority_queue_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata), .in_valid_i(in_valid), .in_port_i(in_port), .out_port_i(out_port),
    .in_tagged_i(in_tagged), .in_tci_i(in_tci), .in_bpdu_i(in_bpdu), .in_handle_i(in_handle),
    .tx_ready_i(tx_ready), .tx_valid_o(tx_valid), .tx_tagged_o(tx_tagged), .tx_tci_o(tx_tci),
    .tx_handle_o(tx_handle), .bpdu_valid_o(bpdu_valid), .bpdu_port_o(bpdu_port),
    .bpdu_handle_o(bpdu_handle));
  egress_sink egress_sink_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .stall_i(stall), .slow_i(slow),
    .tx_ready_o(tx_ready));

  // core clock, 10 ns period
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // timeout and log of every descriptor taken by a station
  always @(posedge clock_i)
  begin
    cycles++;
    for (int p = 0; p < 4; p++)
      if (tx_valid[p] === 1'b1 && tx_ready[p] === 1'b1)
        got_q[p].push_back({tx_tagged[p], tx_tci[p*16+:16], tx_handle[p*16+:16]});
    if (cycles == 5000)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: timeout", $time);
      test_done();
    end
  end

  // register write, one strobe cycle
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock_i);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clock_i);
    reg_wr <= 1'b0;
  endtask

  // register read, data sampled in the cycle after the strobe
  task rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock_i);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock_i);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // one ingress descriptor pulse
  task send(input logic [1:0] ip, input logic [1:0] op, input logic tg, input logic bp,
            input logic [15:0] tci, input logic [15:0] hd);
    @(posedge clock_i);
    in_valid <= 1'b1;
    in_port <= ip;
    out_port <= op;
    in_tagged <= tg;
    in_bpdu <= bp;
    in_tci <= tci;
    in_handle <= hd;
    @(posedge clock_i);
    in_valid <= 1'b0;
  endtask

  // wait bounded for a taken descriptor on one station
  task pop(input logic [1:0] p, output logic [32:0] g);
    int n;
    n = 0;
    while (got_q[p].size() == 0 && n < 60)
    begin
      @(posedge clock_i);
      n++;
    end
    g = '0;
    if (got_q[p].size() == 0)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: no frame on port %0d", $time, p);
    end
    else
      g = got_q[p].pop_front();
  endtask

  task test_done();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // main sequence
  initial
  begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, in_valid, in_port, out_port} = '0;
    {in_tagged, in_tci, in_bpdu, in_handle, stall, slow, rst_n_i} = '0;
    {mismatches, tests_run, cycles} = '0;
    ca = '{8'h00, 8'h40, 8'h44, 8'h48, 8'h4C, 8'h0C, 8'h10, 8'h0C, 8'h10, 8'h0C, 8'h10, 8'h0C, 8'h10};
    cd = '{32'h1, 32'h00050024, 32'h0007006C, 32'h0009000C, 32'h4, 32'h123, 32'h0, 32'h7, 32'h2,
           32'h9, 32'h4, 32'h5, 32'h3};
    rows[0] = '{2'd0, 2'd2, 1'b0, 16'h0000, 1'b1, 16'h4005};
    rows[1] = '{2'd0, 2'd1, 1'b0, 16'h0000, 1'b0, 16'h0000};
    rows[2] = '{2'd1, 2'd2, 1'b1, 16'hA123, 1'b1, 16'hA123};
    rows[3] = '{2'd2, 2'd0, 1'b1, 16'h3009, 1'b0, 16'h0000};
    rows[4] = '{2'd1, 2'd2, 1'b0, 16'h0000, 1'b1, 16'hC007};
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    // reset values and an unmapped address
    rd(8'h04, d); `CHK(d, 32'h4)
    rd(8'h40, d); `CHK(d, 32'h00010000)
    rd(8'hFC, d); `CHK(d, 32'h0)
    $display("reset test done");
    // vlan on, port setup and membership
    for (int i = 0; i < 13; i++)
      wr(ca[i], cd[i]);
    rd(8'h10, d); `CHK(d, 32'h3)
    rd(8'h0C, d); `CHK(d, 32'h5)
    // ordinary frames from the table
    for (int i = 0; i < 5; i++)
    begin
      h = 16'h0010 + 16'(i);
      send(rows[i].inp, rows[i].outp, rows[i].tg, 1'b0, rows[i].tci, h);
      pop(rows[i].outp, got);
      `CHK(got[32], rows[i].etg)
      `CHK(got[15:0], h)
      if (rows[i].etg) `CHK(got[31:16], rows[i].etci)
    end
    $display("table test done");
    // tagged frame on an access port is dropped
    send(2'd0, 2'd1, 1'b1, 1'b0, 16'h2005, 16'h0020);
    // egress port in each non-forwarding state, then forced blocking
    for (int s = 0; s < 4; s++)
    begin
      wr(8'h4C, 32'(s));
      rd(8'h8C, d); `CHK(d, 32'(s))
      send(2'd0, 2'd3, 1'b0, 1'b0, 16'h0000, 16'h0030);
    end
    wr(8'h4C, 32'h84);
    rd(8'h8C, d); `CHK(d, 32'h1)
    send(2'd0, 2'd3, 1'b0, 1'b0, 16'h0000, 16'h0030);
    repeat (4) @(posedge clock_i);
    `CHK(got_q[1].size(), 0)
    `CHK(got_q[3].size(), 0)
    rd(8'h08, d); `CHK(d, 32'h6)
    wr(8'h08, 32'h0);
    rd(8'h08, d); `CHK(d, 32'h0)
    wr(8'h4C, 32'h4);
    send(2'd0, 2'd3, 1'b0, 1'b0, 16'h0000, 16'h0031);
    pop(2'd3, got); `CHK(got[15:0], 16'h0031)
    $display("state test done");
    // bpdu from a blocking port still delivered, from a disabled port not
    wr(8'h4C, 32'h1);
    send(2'd3, 2'd0, 1'b0, 1'b1, 16'h0000, 16'h0040);
    #1 `CHK(bpdu_valid, 1'b1)
    `CHK(bpdu_port, 2'd3)
    `CHK(bpdu_handle, 16'h0040)
    wr(8'h4C, 32'h0);
    send(2'd3, 2'd0, 1'b0, 1'b1, 16'h0000, 16'h0041);
    #1 `CHK(bpdu_valid, 1'b0)
    $display("bpdu test done");
    // strict priority with a stalled then slow station
    @(posedge clock_i);
    stall <= 4'b0100;
    send(2'd1, 2'd2, 1'b1, 1'b0, 16'h6009, 16'h0050);
    send(2'd1, 2'd2, 1'b1, 1'b0, 16'h6009, 16'h0051);
    send(2'd1, 2'd2, 1'b1, 1'b0, 16'h8009, 16'h0052);
    rd(8'h88, d); `CHK(d, 32'h00010104)
    @(posedge clock_i);
    stall <= 4'b0000;
    slow <= 1'b1;
    pop(2'd2, got); `CHK(got[15:0], 16'h0050)
    pop(2'd2, got); `CHK(got[15:0], 16'h0052)
    pop(2'd2, got); `CHK(got[15:0], 16'h0051)
    // threshold raised to 6: level 5 now normal
    wr(8'h04, 32'h6);
    stall <= 4'b0100;
    send(2'd1, 2'd2, 1'b1, 1'b0, 16'hA009, 16'h0060);
    send(2'd1, 2'd2, 1'b1, 1'b0, 16'hA009, 16'h0061);
    rd(8'h88, d); `CHK(d, 32'h00000104)
    // vlan off: no high class, tag flag passes through
    wr(8'h00, 32'h0);
    send(2'd1, 2'd2, 1'b1, 1'b0, 16'hE009, 16'h0062);
    send(2'd1, 2'd2, 1'b0, 1'b0, 16'h0000, 16'h0063);
    rd(8'h88, d); `CHK(d, 32'h00000304)
    @(posedge clock_i);
    stall <= 4'b0000;
    pop(2'd2, got); `CHK(got[15:0], 16'h0060)
    pop(2'd2, got); `CHK(got[15:0], 16'h0061)
    pop(2'd2, got); `CHK(got, 33'h1E0090062)
    pop(2'd2, got); `CHK(got[32], 1'b0)
    $display("priority test done");
    test_done();
  end
endmodule

`default_nettype wire
